// file: hw/mpbc_flow_ctrl.sv
// flow control of an ethernet mac: pause send and obey, half-duplex back pressure
//
// Functional notes
// [R1]: outgoing pause frames carry the programmed pause time from bits 31-16.
// [R2]: software loads the pause time before enabling full-duplex flow control.
// [R3]: full duplex: busy high from pause frame start until completely sent.
// [R4]: half duplex: busy high for the whole back pressure interval.
// [R5]: software checks busy reads zero before writing the control register.
// [R6]: software always writes zero into the busy bit.
// [R7]: pass bit set marks valid pause frames in filter status; clear leaves it clear.
// [R8]: every received frame is forwarded with its status, errors included.
// [R9]: the application keeps or drops each frame from its status.
// [R10]: address filter modes such as promiscuous override the pass bit.
// [R11]: enable set: decode control frames, hold transmitter pause time times slot.
// [R12]: enable clear: no control frame decoding and no action.
// [R13]: received pause acted on only in full duplex with flow control enabled.
// [R14]: half duplex: the enable bit enables back pressure instead.
// [R15]: no pause frames and no back pressure while the transmitter is disabled.
// [R16]: outgoing control frames follow the standard pause frame layout.
// [R17]: one pause quantum is one slot of 512 bit times at link speed.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/100ps
module mpbc_flow_ctrl
  import mpbc_pkg::*;
#(
  parameter int SLOT_CYCLES_10 = SLOT_CYCLES_10_DFLT
)
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [47:0] STATION_ADDR,
  input wire logic PAUSE_REQ,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic TX_LAST,
  output logic TX_HOLD,
  output logic BACKPRESSURE,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic RX_ERR,
  input wire logic RX_ADDR_OK,
  output logic [7:0] RX_OUT_DATA,
  output logic RX_OUT_VALID,
  output logic RX_OUT_SOF,
  output logic RX_OUT_EOF,
  output logic RX_OUT_ERR,
  output logic RX_OUT_FILTER,
  output logic RX_OUT_CTRL
);

  if (SLOT_CYCLES_10 < 1 || SLOT_CYCLES_10 >= (1 << SLOT_W)) begin : g_bad_slot
    $error("SLOT_CYCLES_10 must lie between 1 and 2**SLOT_W-1");
  end

  if (SLOT_CYCLES_100 < 1 || SLOT_CYCLES_100 >= (1 << SLOT_W)) begin : g_bad_slot100
    $error("SLOT_CYCLES_100 must lie between 1 and 2**SLOT_W-1");
  end

  if (DATA_W != 32) begin : g_bad_data_w
    $error("the register images are built for a 32-bit data bus");
  end

  if (ADDR_W != 8) begin : g_bad_addr_w
    $error("the word decode uses address bits 7 to 2");
  end

  if (RX_HDR_LAST != RX_PT_OFS + 5'h01) begin : g_bad_rx_layout
    $error("the pause time must be the last two header bytes");
  end

  if (FLOW_IDX == MODE_IDX || FLOW_IDX == STAT_IDX || MODE_IDX == STAT_IDX) begin : g_bad_map
    $error("register word indices must differ");
  end

  if (TX_LAST_IDX < 6'h11) begin : g_bad_tx_len
    $error("an outgoing pause frame must at least hold its header");
  end

  localparam logic [SLOT_W-1:0] SLOT_RELOAD_100 = SLOT_W'(SLOT_CYCLES_100 - 1);
  localparam logic [SLOT_W-1:0] SLOT_RELOAD_10 = SLOT_W'(SLOT_CYCLES_10 - 1);

  // block state outside the frame generator in one struct, cleared together by the asynchronous reset
  mpbc_state_t st;
  mpbc_state_t next_st;
  logic tx_busy;

  // the frame generator latches the pause time itself at start
  mpbc_pause_tx u_pause_tx (
    .mclk(MCLK),
    .rst_b(RST_B),
    .start(st.start),
    .pause_time(st.pause_time_value),
    .src_addr(STATION_ADDR),
    .busy(tx_busy),
    .tx_data(TX_DATA),
    .tx_valid(TX_VALID),
    .tx_ready(TX_READY),
    .tx_last(TX_LAST)
  );

  // expected byte of a pause frame header and whether it is checked
  function automatic logic [8:0] rx_expect(input logic [4:0] i);
    logic [8:0] e;
    e = 9'h000;
    if (i < RX_DA_END) begin
      e = {1'b1, PAUSE_DA[8 * (5 - i) +: 8]};
    end else if (i == RX_TYPE_OFS) begin
      e = {1'b1, MAC_CTRL_TYPE[15:8]};
    end else if (i == RX_TYPE_OFS + 5'h01) begin
      e = {1'b1, MAC_CTRL_TYPE[7:0]};
    end else if (i == RX_OPC_OFS) begin
      e = {1'b1, PAUSE_OPCODE[15:8]};
    end else if (i == RX_OPC_OFS + 5'h01) begin
      e = {1'b1, PAUSE_OPCODE[7:0]};
    end
    return e;
  endfunction : rx_expect

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        v[8 * b +: 8] = wd[8 * b +: 8];
      end
    end
    return v;
  endfunction : merge

  logic busy_flag;
  logic [31:0] flow_img;
  logic [31:0] mode_img;
  logic [31:0] stat_img;

  // busy follows the frame in full duplex and back pressure in half duplex
  // the start pulse counts too, so busy never drops between request and first byte
  assign busy_flag = st.fdx ? (tx_busy | st.start) : st.bp; // [R3] [R4]

  always_comb begin
    flow_img = '0;
    flow_img[FLOW_PT_LSB +: 16] = st.pause_time_value;
    flow_img[FLOW_PASS_BIT] = st.pass_control_frames;
    flow_img[FLOW_EN_BIT] = st.flow_ctrl_enable;
    flow_img[FLOW_BUSY_BIT] = busy_flag;
    mode_img = '0;
    mode_img[MODE_FDX_BIT] = st.fdx;
    mode_img[MODE_TXEN_BIT] = st.tx_en;
    mode_img[MODE_SPD100_BIT] = st.spd100;
    mode_img[MODE_PROMISC_BIT] = st.promisc;
    // status is read-only, writes to it fall into the default branch
    stat_img = '0;
    stat_img[STAT_HOLD_BIT] = (st.quanta != 16'h0000);
    stat_img[STAT_BP_BIT] = st.bp;
    stat_img[STAT_TXF_BIT] = tx_busy;
    stat_img[STAT_QUANTA_LSB +: 16] = st.quanta;
  end

  logic [4:0] cur_idx;
  logic [8:0] exp_b;
  logic match_now;
  logic [15:0] pt_now;
  logic pause_ok;
  logic [31:0] wv;
  logic [SLOT_W-1:0] slot_reload;

  always_comb begin
    next_st = st;
    wv = '0;
    cur_idx = RX_SOF ? 5'h00 : st.rx_idx;
    exp_b = rx_expect(cur_idx);
    match_now = RX_SOF ? 1'b1 : st.rx_match;
    pt_now = st.rx_pt;
    pause_ok = 1'b0;
    slot_reload = st.spd100 ? SLOT_RELOAD_100 : SLOT_RELOAD_10; // [R17]

    // register bus: one wait cycle, answer on the second
    // a request still high after its answer starts a second access
    // read data is latched in the wait cycle, so it stands at the accepting edge
    next_st.ack = (AVS_READ | AVS_WRITE) & ~st.ack;
    if (AVS_READ && !st.ack) begin
      case (AVS_ADDRESS[7:2])
        FLOW_IDX: next_st.rdata = flow_img;
        MODE_IDX: next_st.rdata = mode_img;
        STAT_IDX: next_st.rdata = stat_img;
        default: next_st.rdata = RD_UNMAPPED;
      endcase
    end
    if (AVS_WRITE && st.ack) begin
      case (AVS_ADDRESS[7:2])
        FLOW_IDX: begin
          // busy is hardware owned, the written bit is dropped
          wv = merge(flow_img, AVS_WRITEDATA, AVS_BYTEENABLE);
          next_st.pause_time_value = wv[FLOW_PT_LSB +: 16];
          next_st.pass_control_frames = wv[FLOW_PASS_BIT];
          next_st.flow_ctrl_enable = wv[FLOW_EN_BIT];
        end
        MODE_IDX: begin
          wv = merge(mode_img, AVS_WRITEDATA, AVS_BYTEENABLE);
          next_st.fdx = wv[MODE_FDX_BIT];
          next_st.tx_en = wv[MODE_TXEN_BIT];
          next_st.spd100 = wv[MODE_SPD100_BIT];
          next_st.promisc = wv[MODE_PROMISC_BIT];
        end
        default: begin
          wv = '0;
        end
      endcase
    end

    // pause send on a rising request, back pressure while it stays high
    // a level request would resend frames back to back, hence the edge
    next_st.req_q = PAUSE_REQ;
    next_st.start = PAUSE_REQ & ~st.req_q & st.fdx & st.tx_en & st.flow_ctrl_enable
                    & ~tx_busy & ~st.start; // [R15]
    next_st.bp = PAUSE_REQ & ~st.fdx & st.tx_en & st.flow_ctrl_enable; // [R14] [R15]

    // receive header decode
    // header bytes other than the source address and pause time are checked as they pass, only the two pause time bytes are stored
    // frames shorter than the header never count as a pause
    if (RX_VALID) begin
      next_st.rx_idx = (cur_idx == RX_IDX_MAX) ? cur_idx : cur_idx + 5'h01;
      if (exp_b[8] && (RX_DATA != exp_b[7:0])) begin
        match_now = 1'b0;
      end
      if (cur_idx == RX_PT_OFS) begin
        pt_now = {RX_DATA, st.rx_pt[7:0]};
      end else if (cur_idx == RX_PT_OFS + 5'h01) begin
        pt_now = {st.rx_pt[15:8], RX_DATA};
      end
      next_st.rx_match = match_now;
      next_st.rx_pt = pt_now;
      // disabled flow control never recognises a control frame
      pause_ok = RX_EOF & st.flow_ctrl_enable & match_now & ~RX_ERR
                 & (cur_idx > RX_HDR_LAST); // [R11] [R12]
    end

    // every byte is forwarded, status rides on the last one
    // anything that is not a recognised pause takes the address filter result
    next_st.out_data = RX_DATA; // [R8]
    next_st.out_valid = RX_VALID;
    next_st.out_sof = RX_VALID & RX_SOF;
    next_st.out_eof = RX_VALID & RX_EOF;
    next_st.out_err = RX_VALID & RX_EOF & RX_ERR; // [R8]
    next_st.out_ctrl = pause_ok;
    if (RX_VALID && RX_EOF) begin
      if (st.promisc) begin
        next_st.out_filter = 1'b1; // [R10]
      end else if (pause_ok) begin
        next_st.out_filter = st.pass_control_frames; // [R7]
      end else begin
        next_st.out_filter = RX_ADDR_OK;
      end
    end else begin
      next_st.out_filter = 1'b0;
    end

    // transmit hold timer, a new pause replaces the running one
    // a pause time of zero ends a running hold at once
    // leaving full duplex drops a running hold instead of letting it expire
    if (!(st.fdx && st.flow_ctrl_enable)) begin
      next_st.quanta = 16'h0000; // [R13]
      next_st.slot = '0;
    end else if (pause_ok) begin
      next_st.quanta = pt_now; // [R11] [R13]
      next_st.slot = slot_reload;
    end else if (st.quanta != 16'h0000) begin
      if (st.slot == '0) begin
        next_st.quanta = st.quanta - 16'h0001; // [R17]
        next_st.slot = slot_reload;
      end else begin
        next_st.slot = st.slot - SLOT_W'(1);
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st.ack;
  assign AVS_READDATA = st.rdata;
  // a level for the whole hold, not a pulse
  assign TX_HOLD = (st.quanta != 16'h0000);
  assign BACKPRESSURE = st.bp;
  assign RX_OUT_DATA = st.out_data;
  assign RX_OUT_VALID = st.out_valid;
  assign RX_OUT_SOF = st.out_sof;
  assign RX_OUT_EOF = st.out_eof;
  assign RX_OUT_ERR = st.out_err;
  assign RX_OUT_FILTER = st.out_filter;
  assign RX_OUT_CTRL = st.out_ctrl;

endmodule : mpbc_flow_ctrl

// file: hw/mpbc_pause_tx.sv
// byte stream generator for outgoing pause control frames
`timescale 1ns/100ps
module mpbc_pause_tx
  import mpbc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [15:0] pause_time,
  input wire logic [47:0] src_addr,
  output logic busy,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_last
);

  mpbc_tx_state_t st;
  mpbc_tx_state_t next_st;

  function automatic logic [7:0] byte_at(input logic [5:0] i, input logic [47:0] sa,
                                         input logic [15:0] pt);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      6'h00: b = PAUSE_DA[47:40];
      6'h01: b = PAUSE_DA[39:32];
      6'h02: b = PAUSE_DA[31:24];
      6'h03: b = PAUSE_DA[23:16];
      6'h04: b = PAUSE_DA[15:8];
      6'h05: b = PAUSE_DA[7:0];
      6'h06: b = sa[47:40];
      6'h07: b = sa[39:32];
      6'h08: b = sa[31:24];
      6'h09: b = sa[23:16];
      6'h0A: b = sa[15:8];
      6'h0B: b = sa[7:0];
      6'h0C: b = MAC_CTRL_TYPE[15:8];
      6'h0D: b = MAC_CTRL_TYPE[7:0];
      6'h0E: b = PAUSE_OPCODE[15:8];
      6'h0F: b = PAUSE_OPCODE[7:0];
      6'h10: b = pt[15:8];
      6'h11: b = pt[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : byte_at

  always_comb begin
    next_st = st;
    if (!st.busy && start) begin
      // time is frozen at start so a late write cannot split the field
      next_st.busy = 1'b1;
      next_st.idx = 6'h00;
      next_st.ptime = pause_time;
      next_st.data = byte_at(6'h00, src_addr, pause_time); // [R16]
    end else if (st.busy && tx_ready) begin
      if (st.idx == TX_LAST_IDX) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.idx = st.idx + 6'h01;
        next_st.data = byte_at(st.idx + 6'h01, src_addr, st.ptime); // [R1] [R16]
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= TX_ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign busy = st.busy;
  assign tx_valid = st.busy;
  assign tx_data = st.data;
  assign tx_last = st.busy && (st.idx == TX_LAST_IDX);

endmodule : mpbc_pause_tx

// file: hw/mpbc_pkg.sv
// constants and state types of the pause and back-pressure flow control block
package mpbc_pkg;

  // register bus
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [5:0] FLOW_IDX = 6'h08;
  localparam logic [5:0] MODE_IDX = 6'h10;
  localparam logic [5:0] STAT_IDX = 6'h11;
  localparam logic [31:0] FLOW_RESET = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // pause_backpressure_control fields
  localparam int FLOW_PT_LSB = 16;
  localparam int FLOW_PASS_BIT = 2;
  localparam int FLOW_EN_BIT = 1;
  localparam int FLOW_BUSY_BIT = 0;

  // link mode register fields
  localparam int MODE_FDX_BIT = 0;
  localparam int MODE_TXEN_BIT = 1;
  localparam int MODE_SPD100_BIT = 2;
  localparam int MODE_PROMISC_BIT = 3;

  // status register fields
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_BP_BIT = 1;
  localparam int STAT_TXF_BIT = 2;
  localparam int STAT_QUANTA_LSB = 16;

  // pause frame layout, fcs appended downstream
  localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
  localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [5:0] TX_LAST_IDX = 6'h3B;
  localparam logic [4:0] RX_TYPE_OFS = 5'h0C;
  localparam logic [4:0] RX_OPC_OFS = 5'h0E;
  localparam logic [4:0] RX_PT_OFS = 5'h10;
  localparam logic [4:0] RX_HDR_LAST = 5'h11;
  localparam logic [4:0] RX_DA_END = 5'h06;
  localparam logic [4:0] RX_IDX_MAX = 5'h1F;

  // timing
  localparam int CLK_NS = 5;
  localparam int SLOT_BITS = 512;
  localparam int BIT_NS_100 = 10;
  localparam int BIT_NS_10 = 100;
  localparam int SLOT_W = 14;
  localparam int SLOT_CYCLES_100 = SLOT_BITS * BIT_NS_100 / CLK_NS;
  localparam int SLOT_CYCLES_10_DFLT = SLOT_BITS * BIT_NS_10 / CLK_NS;

  typedef struct packed {
    logic busy;
    logic [5:0] idx;
    logic [7:0] data;
    logic [15:0] ptime;
  } mpbc_tx_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] pause_time_value;
    logic pass_control_frames;
    logic flow_ctrl_enable;
    logic fdx;
    logic tx_en;
    logic spd100;
    logic promisc;
    logic req_q;
    logic start;
    logic bp;
    logic [4:0] rx_idx;
    logic rx_match;
    logic [15:0] rx_pt;
    logic [15:0] quanta;
    logic [SLOT_W-1:0] slot;
    logic [7:0] out_data;
    logic out_valid;
    logic out_sof;
    logic out_eof;
    logic out_err;
    logic out_filter;
    logic out_ctrl;
  } mpbc_state_t;

  localparam mpbc_tx_state_t TX_ST_RESET = '0;
  localparam mpbc_state_t ST_RESET = '0;

endpackage : mpbc_pkg

// file: testbench/mpbc_flow_ctrl_props.sv
// assertion checker for the flow control block, bound to its top module
`timescale 1ns/100ps
module mpbc_fc_props (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic PAUSE_REQ,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic TX_LAST,
  input wire logic TX_HOLD,
  input wire logic BACKPRESSURE,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic RX_ERR,
  input wire logic [7:0] RX_OUT_DATA,
  input wire logic RX_OUT_VALID,
  input wire logic RX_OUT_SOF,
  input wire logic RX_OUT_EOF,
  input wire logic RX_OUT_ERR,
  input wire logic RX_OUT_FILTER,
  input wire logic RX_OUT_CTRL
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  sequence s_req_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_last_taken;
    TX_VALID && TX_READY && TX_LAST;
  endsequence
  chk_bus_wait_one: assert property (s_req_wait ##1 (AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("waitrequest held beyond one cycle");
  chk_rx_copy_late: assert property (RX_VALID |=> RX_OUT_VALID && RX_OUT_DATA == $past(RX_DATA))
    else $error("received byte not forwarded one cycle later");
  chk_status_only_eof: assert property (!RX_OUT_EOF |-> !RX_OUT_CTRL && !RX_OUT_FILTER && !RX_OUT_ERR)
    else $error("receive status outside end of frame");
  chk_err_forward: assert property (RX_VALID && RX_EOF |=> RX_OUT_ERR == $past(RX_ERR))
    else $error("frame error status lost");
  chk_sof_forward: assert property (RX_VALID && RX_SOF |=> RX_OUT_SOF)
    else $error("frame start not forwarded");
  chk_frame_tail: assert property (s_last_taken |=> !TX_VALID)
    else $error("pause frame runs past its last byte");
  chk_tx_byte_held: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("pause byte changed while stalled");
  chk_bp_cause: assert property (BACKPRESSURE |-> $past(PAUSE_REQ))
    else $error("back pressure without request");
  chk_tx_start_cause: assert property ($rose(TX_VALID) |-> $past(PAUSE_REQ, 2))
    else $error("pause frame started without request");
  chk_hold_cause: assert property ($rose(TX_HOLD) |-> $past(RX_EOF) && $past(RX_VALID))
    else $error("transmit hold without received frame end");
endmodule : mpbc_fc_props

bind mpbc_flow_ctrl mpbc_fc_props u_props (.MCLK, .RST_B, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .PAUSE_REQ, .TX_DATA, .TX_VALID, .TX_READY, .TX_LAST, .TX_HOLD, .BACKPRESSURE, .RX_DATA,
  .RX_VALID, .RX_SOF, .RX_EOF, .RX_ERR, .RX_OUT_DATA, .RX_OUT_VALID, .RX_OUT_SOF,
  .RX_OUT_EOF, .RX_OUT_ERR, .RX_OUT_FILTER, .RX_OUT_CTRL);

// file: testbench/mpbc_station_model.sv
// remote station: takes outgoing pause bytes, sends pause frames inward
`timescale 1ns/100ps
module mpbc_station_model
  import mpbc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid = 1'b0,
  output logic rx_sof = 1'b0,
  output logic rx_eof = 1'b0,
  output logic rx_err = 1'b0
);
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] tx_buf [0:63];
  int tx_n = 0;
  // no stale byte between frames
  assign rx_data = rx_valid ? rx_byte : ~rx_byte;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) tx_ready <= 1'b0;
    else tx_ready <= stall ? ~tx_ready : 1'b1;
  end
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      if (tx_n < 64) tx_buf[tx_n] <= tx_data;
      tx_n <= tx_n + 1;
    end
  end
  task clr;
    tx_n = 0;
  endtask : clr
  task send(input logic [15:0] pt, input logic err);
    logic [479:0] f;
    f = {PAUSE_DA, 48'h0200_0000_0009, MAC_CTRL_TYPE, PAUSE_OPCODE, pt, 336'h0};
    for (int i = 0; i < 60; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_byte <= f[479-8*i -: 8];
      rx_sof <= (i == 0);
      rx_eof <= (i == 59);
      rx_err <= err && (i == 59);
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_eof <= 1'b0;
    rx_err <= 1'b0;
  endtask : send
endmodule : mpbc_station_model

// file: testbench/tb_top.sv
// self-checking bench for the flow control block
`timescale 1ns/100ps
module tb_top
  import mpbc_pkg::*;
;
  localparam int SLOT10 = 16;
  localparam logic [47:0] STA = 48'h0200_1234_5678;
  localparam logic [479:0] FR = {PAUSE_DA, STA, MAC_CTRL_TYPE, PAUSE_OPCODE, 16'h1234, 336'h0};
  localparam logic [7:0] A_FLOW = {FLOW_IDX, 2'b00};
  localparam logic [7:0] A_MODE = {MODE_IDX, 2'b00};
  localparam logic [7:0] A_STAT = {STAT_IDX, 2'b00};
  logic MCLK = 1'b0, RST_B = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, PAUSE_REQ = 1'b0;
  logic [7:0] AVS_ADDRESS = 8'h00, TX_DATA, RX_DATA, RX_OUT_DATA;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000, AVS_READDATA, got;
  logic AVS_WAITREQUEST, TX_VALID, TX_READY, TX_LAST, TX_HOLD, BACKPRESSURE;
  logic RX_VALID, RX_SOF, RX_EOF, RX_ERR, RX_ADDR_OK = 1'b0, stall = 1'b0;
  logic RX_OUT_VALID, RX_OUT_SOF, RX_OUT_EOF, RX_OUT_ERR, RX_OUT_FILTER, RX_OUT_CTRL;
  logic s_ctl, s_flt, s_err, pz, ef;
  logic [3:0] c_fl [6] = '{4'h6, 4'h2, 4'h2, 4'h0, 4'h2, 4'h2};
  logic [3:0] c_md [6] = '{4'h3, 4'h3, 4'hB, 4'h3, 4'h2, 4'h3};
  logic c_er [6] = '{0, 0, 0, 0, 0, 1};
  logic c_ok [6] = '{0, 1, 0, 1, 0, 0};
  int mismatches = 0, tests_run = 0, cycles = 0, hold_n = 0, h0, eh;
  mpbc_flow_ctrl #(.SLOT_CYCLES_10(SLOT10)) uut (.MCLK, .RST_B, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hF), .AVS_READDATA, .AVS_WAITREQUEST,
    .STATION_ADDR(STA), .PAUSE_REQ, .TX_DATA, .TX_VALID, .TX_READY, .TX_LAST, .TX_HOLD,
    .BACKPRESSURE, .RX_DATA, .RX_VALID, .RX_SOF, .RX_EOF, .RX_ERR, .RX_ADDR_OK,
    .RX_OUT_DATA, .RX_OUT_VALID, .RX_OUT_SOF, .RX_OUT_EOF, .RX_OUT_ERR, .RX_OUT_FILTER,
    .RX_OUT_CTRL);
  mpbc_station_model st (.mclk(MCLK), .rst_b(RST_B), .stall(stall), .tx_data(TX_DATA),
    .tx_valid(TX_VALID), .tx_ready(TX_READY), .rx_data(RX_DATA), .rx_valid(RX_VALID),
    .rx_sof(RX_SOF), .rx_eof(RX_EOF), .rx_err(RX_ERR));
  always #2.5 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (RX_OUT_EOF) {s_err, s_flt, s_ctl} <= {RX_OUT_ERR, RX_OUT_FILTER, RX_OUT_CTRL};
    if (TX_HOLD) hold_n <= hold_n + 1;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    // read right after an edge, these are the values that edge sampled
    @(posedge MCLK);
    while (AVS_WAITREQUEST) @(posedge MCLK);
    got = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(got, exp);
  endtask : rd
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (8) @(posedge MCLK);
    RST_B <= 1'b1;
    rd(A_FLOW, FLOW_RESET);
    rd(A_MODE, 32'h0000_0000);
    rd(A_STAT, 32'h0000_0000);
    bus(1'b1, 8'h7C, 32'hFFFF_FFFF);
    rd(8'h7C, RD_UNMAPPED);
    bus(1'b1, A_FLOW, 32'h1234_0000);
    bus(1'b1, A_FLOW, 32'h1234_0006);
    rd(A_FLOW, 32'h1234_0006);
    bus(1'b1, A_MODE, 32'h0000_0003);
    stall <= 1'b1;
    PAUSE_REQ <= 1'b1;
    rd(A_FLOW, 32'h1234_0007);
    while (st.tx_n < 60) @(posedge MCLK);
    PAUSE_REQ <= 1'b0;
    stall <= 1'b0;
    rd(A_FLOW, 32'h1234_0006);
    chk(32'(st.tx_n), 32'h0000_003C);
    for (int i = 0; i < 60; i++) chk({24'h0, st.tx_buf[i]}, {24'h0, FR[479-8*i -: 8]});
    st.clr();
    bus(1'b1, A_MODE, 32'h0000_0001);
    PAUSE_REQ <= 1'b1;
    repeat (80) @(posedge MCLK);
    PAUSE_REQ <= 1'b0;
    chk(32'(st.tx_n), 32'h0000_0000);
    bus(1'b1, A_MODE, 32'h0000_0002);
    PAUSE_REQ <= 1'b1;
    rd(A_FLOW, 32'h1234_0007);
    chk({31'h0, BACKPRESSURE}, 32'h0000_0001);
    PAUSE_REQ <= 1'b0;
    rd(A_FLOW, 32'h1234_0006);
    bus(1'b1, A_MODE, 32'h0000_0000);
    PAUSE_REQ <= 1'b1;
    repeat (4) @(posedge MCLK);
    chk({31'h0, BACKPRESSURE}, 32'h0000_0000);
    PAUSE_REQ <= 1'b0;
    // received pause across enable, pass, promiscuous, duplex and error cases
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, A_FLOW, {16'h0003, 12'h000, c_fl[k]});
      bus(1'b1, A_MODE, {28'h0, c_md[k]});
      RX_ADDR_OK <= c_ok[k];
      {s_err, s_flt, s_ctl} = 'x;
      h0 = hold_n;
      st.send(16'h0003, c_er[k]);
      repeat (60) @(posedge MCLK);
      pz = c_fl[k][1] && !c_er[k];
      ef = c_md[k][3] | (pz ? c_fl[k][2] : c_ok[k]);
      eh = (pz && c_md[k][0]) ? 3 * SLOT10 : 0;
      chk({29'h0, s_err, s_flt, s_ctl}, {29'h0, c_er[k], ef, pz});
      chk(32'(hold_n - h0), 32'(eh));
    end
    // 100 Mb/s slot length, hold read back mid pause
    bus(1'b1, A_MODE, 32'h0000_0007);
    rd(A_MODE, 32'h0000_0007);
    h0 = hold_n;
    st.send(16'h0001, 1'b0);
    rd(A_STAT, {16'h0001, 16'h0001});
    repeat (1040) @(posedge MCLK);
    chk(32'(hold_n - h0), 32'(SLOT_CYCLES_100));
    give_verdict();
  end
endmodule : tb_top
